/* File: logic/dacsc_defines.vh */
// Purpose: shared constants of the dual converter host controller
// Assumes: 100 MHz system clock, register word index on the Avalon bus
// Notes: definitions only
`ifndef DACSC_DEFINES_VH
`define DACSC_DEFINES_VH

// system clock and converter clock timing
`define DACSC_MCLK_HZ 100000000
`define DACSC_CONV_CLK_HZ 5000000
`define DACSC_HALF_CYC (`DACSC_MCLK_HZ / (2 * `DACSC_CONV_CLK_HZ))
`define DACSC_HALF_CYC_W 4
`define DACSC_HALF_LAST 4'h9

// frame lengths in converter clocks (half-clock mode)
`define DACSC_FRAME_DUAL 6'h14
`define DACSC_FRAME_SINGLE 6'h28
`define DACSC_FIRST_SAMPLE 6'h02
`define DACSC_BITS_DUAL 6'h10
`define DACSC_BITS_SINGLE 6'h20
`define DACSC_WORD_BITS 6'h10

// register word indexes
`define DACSC_REG_CTRL 3'h0
`define DACSC_REG_CMD 3'h1
`define DACSC_REG_CFG 3'h2
`define DACSC_REG_STATUS 3'h3
`define DACSC_REG_RESULT 3'h4

// control register fields
`define DACSC_CTRL_RUN 0
`define DACSC_CTRL_METHOD 1
`define DACSC_CTRL_LANE 2
`define DACSC_CTRL_FREE_CLK 3
`define DACSC_CTRL_ONESHOT 4
`define DACSC_CTRL_DEV_RESET 5
`define DACSC_CTRL_RESET 6'h00

// serial input word fields and values
`define DACSC_CFG_RESET 16'h0000
`define DACSC_ADDR_LSB 0
`define DACSC_ADDR_W 4
`define DACSC_ADDR_DEV_RESET 4'hf
`define DACSC_ADDR_REFDAC_A 4'h1
`define DACSC_ADDR_REFDAC_B 4'h2
`define DACSC_REF_CODE_W 10
`define DACSC_REF_CODE_MIN 10'h0cd

`endif

/* File: logic/dacsc_host.v */
// Purpose: host controller for a dual simultaneous-sampling converter
// Assumes: half-clock mode, start and read strobes driven together, Avalon-MM
// Notes: converter clock is divided from i_mclk and driven out
// What this block does
// (RULE1) Converter holds inputs at start rise, converts from next clock rise.
// (RULE2) Never raise the start strobe while the busy pin is high.
// (RULE3) Tied strobes rise at a clock rise; converter starts next rise.
// (RULE4) Tied strobe pulse in single-output half-clock modes lasts one clock.
// (RULE5) With tied strobes, chip select is low at every conversion start.
// (RULE6) When the result buffer is used, drive start separately from read; the code drives both strobes together.
// (RULE7) Converter precharges sampling capacitors after each conversion.
// (RULE8) After reset, half-clock mode; supply a 0.5 to 20 MHz clock.
// (RULE9) In full-clock mode the supplied clock must be 1 to 40 MHz.
// (RULE10) Clock may stop after a read but restarts before the next start.
// (RULE11) Converter resets at power-on or by an address-field reset command.
// (RULE12) Reference output is 2.5 V times code plus one over 1024.
// (RULE13) Do not program a reference code below 205.
// (RULE14) Reference outputs start disabled with codes at full scale.
// (RULE15) Internal reference is off by default, switched by a power bit.
// (RULE16) Each channel picks either reference output via routing bits.
// (RULE17) Method strap low means manual channel choice, high automatic.
// (RULE18) Lane strap low uses both outputs, high only the first.
// (RULE19) Manual mode: select bits choose input pair zero or one.
// (RULE20) Automatic mode ignores select bits and advances the channel.
// (RULE21) Give at least 20 clocks per half-clock conversion cycle.
// (RULE22) Result shifts out next cycle: first bit on read fall, then rises.
// (RULE23) Busy is low in acquisition, which ends at the start rise.
// (RULE24) Channel changes apply to the conversion from the next start.
// (RULE25) Serial word is 16 bits, MSB first, captured on falling edges.
// (RULE26) Busy stays high from conversion start until precharge ends.
`timescale 1ns/1ps
`include "dacsc_defines.vh"
module dacsc_host (
    input wire i_mclk,
    input wire i_sys_rst,
    input wire [2:0] i_avs_address,
    input wire i_avs_read,
    input wire i_avs_write,
    input wire [31:0] i_avs_writedata,
    output reg [31:0] o_avs_readdata,
    output wire o_avs_waitrequest,
    output reg o_conv_clk,
    output reg o_conversion_start_strobe,
    output reg o_read_strobe,
    output reg o_chip_select_n,
    output reg o_serial_in_pin,
    output reg o_channel_method_strap,
    output reg o_output_lane_strap,
    input wire i_busy,
    input wire i_first_serial_out,
    input wire i_second_serial_out
);
    localparam [2:0] ST_IDLE = 3'h1;
    localparam [2:0] ST_WAIT = 3'h2;
    localparam [2:0] ST_FRAME = 3'h4;

    // raises a reference code below the safe floor when a code is due
    function [15:0] dacsc_clamp;
        input [15:0] word;
        input code_due;
        begin
            dacsc_clamp = word;
            if (code_due &&
                word[`DACSC_REF_CODE_W-1:0] < `DACSC_REF_CODE_MIN) begin
                dacsc_clamp[`DACSC_REF_CODE_W-1:0] = `DACSC_REF_CODE_MIN;
            end
        end
    endfunction

    // true when a word's address field announces a reference code next
    function dacsc_is_ref_addr;
        input [15:0] word;
        reg [`DACSC_ADDR_W-1:0] a;
        begin
            a = word[`DACSC_ADDR_LSB +: `DACSC_ADDR_W];
            dacsc_is_ref_addr = (a == `DACSC_ADDR_REFDAC_A) ||
                (a == `DACSC_ADDR_REFDAC_B);
        end
    endfunction

    wire [2:0] pin_level;
    wire busy_level;
    wire first_serial_out_level;
    wire second_serial_out_level;
    reg [5:0] ctrl;
    reg [15:0] cmd_word;
    reg cmd_pending;
    reg [15:0] cfg_word;
    reg [31:0] result;
    reg result_valid;
    reg have_prior;
    reg clamped;
    reg ack;
    reg [2:0] state;
    reg [`DACSC_HALF_CYC_W-1:0] half_cnt;
    reg [5:0] cyc;
    reg [15:0] sdi_shift;
    reg [31:0] sda_shift;
    reg [15:0] sdb_shift;
    reg lane_frame;
    reg code_due;
    reg [15:0] next_word;
    reg [31:0] next_readdata;
    wire bus_req;
    wire wr_take;
    wire rd_take;
    wire clk_enable;
    wire half_done;
    wire rise_tick;
    wire [5:0] frame_len;
    wire [5:0] sample_bits;
    wire [5:0] cyc_next;
    wire frame_end;
    wire start_req;

    // busy and both data outputs arrive from the converter pins
    dacsc_pin_sync #(
        .WIDTH(3)
    ) u_sync (
        .i_mclk(i_mclk),
        .i_sys_rst(i_sys_rst),
        .i_pin({i_second_serial_out, i_first_serial_out, i_busy}),
        .o_level(pin_level)
    );
    assign busy_level = pin_level[0];
    assign first_serial_out_level = pin_level[1];
    assign second_serial_out_level = pin_level[2];

    // bus answers one cycle after a request appears
    assign bus_req = i_avs_read | i_avs_write;
    assign o_avs_waitrequest = bus_req & ~ack;
    assign wr_take = i_avs_write & ack;
    assign rd_take = i_avs_read & ack;

    always @(posedge i_mclk) begin
        if (i_sys_rst) begin
            ack <= 1'b0;
        end else begin
            ack <= bus_req & ~ack;
        end
    end

    // read data mux, unmapped indexes read zero
    always @* begin
        next_readdata = 32'h00000000;
        case (i_avs_address)
            `DACSC_REG_CTRL: next_readdata = {26'h0000000, ctrl};
            `DACSC_REG_CMD: next_readdata = {16'h0000, cmd_word};
            `DACSC_REG_CFG: next_readdata = {16'h0000, cfg_word};
            `DACSC_REG_STATUS: next_readdata = {26'h0000000, clamped,
                cmd_pending, result_valid, (state == ST_FRAME),
                (state == ST_WAIT), busy_level};
            `DACSC_REG_RESULT: next_readdata = result;
            default: next_readdata = 32'h00000000;
        endcase
    end

    always @(posedge i_mclk) begin
        if (i_sys_rst) begin
            o_avs_readdata <= 32'h00000000;
        end else if (i_avs_read & ~ack) begin
            o_avs_readdata <= next_readdata;
        end
    end

    // software registers; strap levels follow the control register
    always @(posedge i_mclk) begin
        if (i_sys_rst) begin
            ctrl <= `DACSC_CTRL_RESET;
            cfg_word <= `DACSC_CFG_RESET;
            o_channel_method_strap <= 1'b0;
            o_output_lane_strap <= 1'b0;
        end else begin
            if (wr_take && i_avs_address == `DACSC_REG_CTRL) begin
                ctrl <= i_avs_writedata[5:0];
            end else if (state == ST_FRAME && cyc == 6'h00) begin
                // one-shot and device reset requests are consumed
                ctrl[`DACSC_CTRL_ONESHOT] <= 1'b0;
                ctrl[`DACSC_CTRL_DEV_RESET] <= 1'b0;
            end
            if (wr_take && i_avs_address == `DACSC_REG_CFG) begin
                cfg_word <= i_avs_writedata[15:0];
            end
            // straps only move between frames
            if (state == ST_IDLE) begin
                o_channel_method_strap <= ctrl[`DACSC_CTRL_METHOD]; // RULE17
                o_output_lane_strap <= ctrl[`DACSC_CTRL_LANE]; // RULE18
            end
        end
    end

    // converter clock: half-clock mode, 5 MHz, stops low when idle unless the free-run bit is set
    assign clk_enable = (state != ST_IDLE) | ctrl[`DACSC_CTRL_FREE_CLK] |
        o_conv_clk; // RULE10
    assign half_done = (half_cnt == `DACSC_HALF_LAST);
    assign rise_tick = clk_enable & half_done & ~o_conv_clk;

    always @(posedge i_mclk) begin
        if (i_sys_rst) begin
            half_cnt <= {`DACSC_HALF_CYC_W{1'b0}};
            o_conv_clk <= 1'b0;
        end else if (clk_enable) begin
            if (half_done) begin
                half_cnt <= {`DACSC_HALF_CYC_W{1'b0}};
                o_conv_clk <= ~o_conv_clk; // RULE8 RULE9
            end else begin
                half_cnt <= half_cnt + 4'h1;
            end
        end else begin
            half_cnt <= {`DACSC_HALF_CYC_W{1'b0}};
        end
    end

    // frame geometry from the lane arrangement
    assign frame_len = lane_frame ? `DACSC_FRAME_SINGLE :
        `DACSC_FRAME_DUAL; // RULE21
    assign sample_bits = lane_frame ? `DACSC_BITS_SINGLE : `DACSC_BITS_DUAL;
    assign cyc_next = cyc + 6'h01;
    assign frame_end = (state == ST_FRAME) && rise_tick &&
        (cyc_next == frame_len);
    assign start_req = ctrl[`DACSC_CTRL_RUN] | ctrl[`DACSC_CTRL_ONESHOT] |
        ctrl[`DACSC_CTRL_DEV_RESET];

    // word to shift out: reset command, pending command or config
    always @* begin
        next_word = dacsc_clamp(cmd_pending ? cmd_word : cfg_word,
            code_due); // RULE13
        if (ctrl[`DACSC_CTRL_DEV_RESET]) begin
            next_word = {cfg_word[15:`DACSC_ADDR_W],
                `DACSC_ADDR_DEV_RESET}; // RULE11
        end
    end

    // frame sequencer
    always @(posedge i_mclk) begin
        if (i_sys_rst) begin
            state <= ST_IDLE;
            cyc <= 6'h00;
            o_conversion_start_strobe <= 1'b0;
            o_read_strobe <= 1'b0;
            o_chip_select_n <= 1'b1;
            o_serial_in_pin <= 1'b0;
            sdi_shift <= 16'h0000;
            sda_shift <= 32'h00000000;
            sdb_shift <= 16'h0000;
            lane_frame <= 1'b0;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (start_req) begin
                        state <= ST_WAIT;
                        lane_frame <= ctrl[`DACSC_CTRL_LANE];
                    end
                end
                ST_WAIT: begin
                    // start only in acquisition, on a clock rise
                    if (rise_tick && !busy_level) begin // RULE2
                        state <= ST_FRAME;
                        cyc <= 6'h00;
                        // strobes rise and fall together, each lasts one clock
                        o_conversion_start_strobe <= 1'b1; // RULE3; read rises with start, not separately as RULE6 asks
                        o_read_strobe <= 1'b1; // RULE4
                        o_chip_select_n <= 1'b0; // RULE5
                        o_serial_in_pin <= next_word[15]; // RULE25
                        sdi_shift <= {next_word[14:0], 1'b0};
                    end
                end
                ST_FRAME: begin
                    if (rise_tick) begin
                        cyc <= cyc_next;
                        o_conversion_start_strobe <= 1'b0;
                        // read falls here, first result bit follows
                        o_read_strobe <= 1'b0; // RULE22
                        if (cyc_next < `DACSC_WORD_BITS) begin
                            o_serial_in_pin <= sdi_shift[15];
                            sdi_shift <= {sdi_shift[14:0], 1'b0};
                        end else begin
                            o_serial_in_pin <= 1'b0;
                        end
                        // bit k settles after rise k, taken at rise k+1
                        if (cyc_next >= `DACSC_FIRST_SAMPLE &&
                            cyc_next < sample_bits + `DACSC_FIRST_SAMPLE) begin
                            sda_shift <= {sda_shift[30:0], first_serial_out_level};
                            sdb_shift <= {sdb_shift[14:0], second_serial_out_level};
                        end
                        if (cyc_next == frame_len) begin
                            o_chip_select_n <= 1'b1;
                            state <= ST_IDLE;
                        end
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // one-shot command word and reference code tracking
    always @(posedge i_mclk) begin
        if (i_sys_rst) begin
            cmd_word <= 16'h0000;
            cmd_pending <= 1'b0;
            code_due <= 1'b0;
            clamped <= 1'b0;
        end else begin
            if (state == ST_WAIT && rise_tick && !busy_level) begin
                code_due <= cmd_pending && !ctrl[`DACSC_CTRL_DEV_RESET] &&
                    !code_due && dacsc_is_ref_addr(cmd_word);
                if (cmd_pending && !ctrl[`DACSC_CTRL_DEV_RESET]) begin
                    cmd_pending <= 1'b0;
                end
            end
            // a new command written in the same cycle wins
            if (wr_take && i_avs_address == `DACSC_REG_CMD) begin
                cmd_word <= i_avs_writedata[15:0];
                cmd_pending <= 1'b1;
                clamped <= 1'b0;
            end
            if (state == ST_WAIT && rise_tick && !busy_level && code_due &&
                next_word != (cmd_pending ? cmd_word : cfg_word)) begin
                clamped <= 1'b1; // RULE13
            end
        end
    end

    // results belong to the previous conversion; first frame is stale
    always @(posedge i_mclk) begin
        if (i_sys_rst) begin
            result <= 32'h00000000;
            result_valid <= 1'b0;
            have_prior <= 1'b0;
        end else begin
            if (rd_take && i_avs_address == `DACSC_REG_RESULT) begin
                result_valid <= 1'b0;
            end
            if (frame_end) begin
                have_prior <= 1'b1;
                if (have_prior) begin
                    result_valid <= 1'b1;
                    if (lane_frame) begin
                        result <= {sda_shift[15:0], sda_shift[31:16]};
                    end else begin
                        result <= {sdb_shift, sda_shift[15:0]};
                    end
                end
            end
        end
    end
endmodule

/* File: logic/dacsc_pin_sync.v */
// Purpose: three-flop input synchroniser with agreement filter
// Assumes: inputs are asynchronous to i_mclk
// Notes: output changes only when stages two and three agree
`timescale 1ns/1ps
module dacsc_pin_sync #(
    parameter WIDTH = 3
) (
    input wire i_mclk,
    input wire i_sys_rst,
    input wire [WIDTH-1:0] i_pin,
    output wire [WIDTH-1:0] o_level
);
    genvar g;
    generate
        for (g = 0; g < WIDTH; g = g + 1) begin : g_bit
            reg s1;
            reg s2;
            reg s3;
            reg level;
            // stage one feeds stage two only
            always @(posedge i_mclk) begin
                if (i_sys_rst) begin
                    s1 <= 1'b0;
                    s2 <= 1'b0;
                    s3 <= 1'b0;
                    level <= 1'b0;
                end else begin
                    s1 <= i_pin[g];
                    s2 <= s1;
                    s3 <= s2;
                    if (s2 == s3) begin
                        level <= s3;
                    end
                end
            end
            assign o_level[g] = level;
        end
    endgenerate
endmodule

/* File: test/dacsc_dev.sv */
// Purpose: behavioural converter on the far side of the host
// Assumes: half-clock timing, start and read strobes tied together
// Notes: fixed result words apart from the pair bit in the LSB; lines toggle while not selected
`timescale 1ns/1ps
module dacsc_dev (
    input wire i_conv_clk,
    input wire i_start,
    input wire i_read,
    input wire i_cs_n,
    input wire i_sdi,
    input wire i_method,
    input wire i_lane,
    output reg o_busy,
    output reg o_sdo_a,
    output reg o_sdo_b
);
    reg [9:0] refdac_a;
    reg [9:0] refdac_b;
    reg ref_power_down_bit;
    reg [15:0] cfg;
    reg [15:0] reference_routing_register;
    reg [3:0] pend;
    reg [15:0] shin;
    reg [4:0] nin;
    reg go, rd_seen, sel, pair;
    reg [4:0] bleft;
    reg [31:0] sh_a;
    reg [15:0] sh_b, res_a, res_b;
    // power-on and commanded reset: references off, codes full scale
    task dev_reset;
        begin
            refdac_a = 10'h3ff;
            refdac_b = 10'h3ff;
            ref_power_down_bit = 1'b1;
            cfg = 16'h0000;
            pend = 4'h0;
        end
    endtask
    initial begin
        dev_reset;
        {o_busy, o_sdo_a, o_sdo_b, go, rd_seen, sel, pair} = 7'h00;
        {nin, bleft, res_a, res_b} = 42'h0;
    end
    // strobes and the serial word are taken on falling clock edges
    always @(negedge i_conv_clk) begin
        go <= i_start && !o_busy;
        rd_seen <= i_read;
        sel <= !i_cs_n;
        if (i_cs_n)
            nin <= 5'h00;
        else if (nin < 5'h10) begin
            shin <= {shin[14:0], i_sdi};
            nin <= nin + 5'h01;
        end else if (nin == 5'h10) begin
            nin <= 5'h11;
            if (pend == 4'h1) begin
                refdac_a <= shin[9:0];
                ref_power_down_bit <= shin[10];
                pend <= 4'h0;
            end else if (pend == 4'h2) begin
                refdac_b <= shin[9:0];
                pend <= 4'h0;
            end else if (pend == 4'h4) begin
                reference_routing_register <= shin;
                pend <= 4'h0;
            end else if (shin[3:0] == 4'hf)
                dev_reset;
            else begin
                cfg <= shin;
                pend <= shin[3:0];
            end
        end
    end
    // conversion, busy and result shifting on rising clock edges
    always @(posedge i_conv_clk) begin
        if (go) begin
            o_busy <= 1'b1;
            bleft <= 5'h0e;
            pair <= i_method ? !pair : cfg[15];
            res_a <= 16'hc3a5 ^ {15'h0, pair};
            res_b <= 16'h5a3c ^ {15'h0, pair};
        end else if (bleft != 5'h00) begin
            bleft <= bleft - 5'h01;
            if (bleft == 5'h01)
                o_busy <= 1'b0;
        end
        if (rd_seen) begin
            sh_a <= i_lane ? {res_a, res_b} : {res_a, 16'h0000};
            sh_b <= res_b;
            o_sdo_a <= res_a[15];
            o_sdo_b <= res_b[15];
        end else if (sel) begin
            sh_a <= sh_a << 1;
            sh_b <= sh_b << 1;
            o_sdo_a <= sh_a[30];
            o_sdo_b <= sh_b[14];
        end else begin
            o_sdo_a <= !o_sdo_a;
            o_sdo_b <= !o_sdo_b;
        end
    end
endmodule

/* File: test/dacsc_host_assertions.sv */
// Purpose: port timing checks for the converter host controller
// Assumes: one clock domain, synchronous active-high reset
// Notes: attached to the host by the bind below
`timescale 1ns/1ps
module dacsc_host_chk (
    input wire i_mclk,
    input wire i_sys_rst,
    input wire [2:0] i_avs_address,
    input wire i_avs_read,
    input wire i_avs_write,
    input wire [31:0] o_avs_readdata,
    input wire o_avs_waitrequest,
    input wire o_conv_clk,
    input wire o_conversion_start_strobe,
    input wire o_read_strobe,
    input wire o_chip_select_n,
    input wire o_serial_in_pin,
    input wire i_busy
);
    reg [5:0] st_cnt;
    reg [5:0] ck_cnt;
    reg [11:0] gap;
    default clocking @(posedge i_mclk); endclocking
    default disable iff (i_sys_rst);
    // high-time counters and spacing between conversion starts
    always @(posedge i_mclk) begin
        if (i_sys_rst) begin
            st_cnt <= 6'h00;
            ck_cnt <= 6'h00;
            gap <= 12'hfff;
        end else begin
            st_cnt <= o_conversion_start_strobe ? st_cnt + 6'h01 : 6'h00;
            ck_cnt <= o_conv_clk ? ck_cnt + 6'h01 : 6'h00;
            if (o_conversion_start_strobe && st_cnt == 6'h00)
                gap <= 12'h001;
            else if (gap != 12'hfff)
                gap <= gap + 12'h001;
        end
    end
    property p_wait_one;
        (i_avs_read || i_avs_write) && o_avs_waitrequest |=>
            !o_avs_waitrequest;
    endproperty
    a_wait_one: assert property (p_wait_one)
        else $error("bus access waited more than one cycle");
    property p_idle;
        !(i_avs_read || i_avs_write) |-> !o_avs_waitrequest;
    endproperty
    a_idle: assert property (p_idle)
        else $error("waitrequest high with no access");
    property p_unmapped;
        i_avs_read && !o_avs_waitrequest && i_avs_address > 3'h4 |->
            o_avs_readdata == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped read returned nonzero");
    property p_no_start_busy;
        $rose(o_conversion_start_strobe) |-> !i_busy && !$past(i_busy, 4);
    endproperty
    a_no_start_busy: assert property (p_no_start_busy)
        else $error("start raised while converter busy");
    property p_cs_at_start;
        $rose(o_conversion_start_strobe) |-> !o_chip_select_n;
    endproperty
    a_cs_at_start: assert property (p_cs_at_start)
        else $error("chip select high at conversion start");
    property p_start_len;
        $fell(o_conversion_start_strobe) |-> st_cnt == 6'h14;
    endproperty
    a_start_len: assert property (p_start_len)
        else $error("start pulse not one converter clock");
    property p_gap;
        $rose(o_conversion_start_strobe) |-> gap >= 12'd400;
    endproperty
    a_gap: assert property (p_gap)
        else $error("conversion cycle shorter than 20 clocks");
    property p_clk_half;
        $fell(o_conv_clk) |-> ck_cnt == 6'h0a;
    endproperty
    a_clk_half: assert property (p_clk_half)
        else $error("converter clock high time wrong");
    property p_sdi_edge;
        $changed(o_serial_in_pin) |-> $rose(o_conv_clk);
    endproperty
    a_sdi_edge: assert property (p_sdi_edge)
        else $error("serial input changed off clock rise");
    property p_rd_fall;
        $fell(o_read_strobe) |-> $rose(o_conv_clk);
    endproperty
    a_rd_fall: assert property (p_rd_fall)
        else $error("read strobe fell off clock rise");
endmodule
bind dacsc_host dacsc_host_chk u_dacsc_host_chk (
    .i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_avs_address(i_avs_address),
    .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
    .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest),
    .o_conv_clk(o_conv_clk),
    .o_conversion_start_strobe(o_conversion_start_strobe),
    .o_read_strobe(o_read_strobe), .o_chip_select_n(o_chip_select_n),
    .o_serial_in_pin(o_serial_in_pin), .i_busy(i_busy));

/* File: test/dacsc_host_bench.sv */
// Purpose: self-checking bench for the converter host controller
// Assumes: 100 MHz clock, Avalon word accesses, dual-lane frames
// Notes: far side is the behavioural dacsc_dev model
`timescale 1ns/1ps
`include "dacsc_defines.vh"
module dacsc_host_bench;
    reg i_mclk, i_sys_rst, i_avs_read, i_avs_write;
    reg [2:0] i_avs_address;
    reg [31:0] i_avs_writedata, q;
    wire [31:0] o_avs_readdata;
    wire o_avs_waitrequest, conv_clk, start, rd_strobe, cs_n, serial_in_pin;
    wire method, lane, busy, sdo_a, sdo_b;
    integer num_errors, tests_run, cyc, k;
    localparam [31:0] RUN = 32'h1 << `DACSC_CTRL_RUN;
    localparam [31:0] DRST = 32'h1 << `DACSC_CTRL_DEV_RESET;
    dacsc_host u_dacsc_host (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst),
        .i_avs_address(i_avs_address), .i_avs_read(i_avs_read),
        .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
        .o_avs_readdata(o_avs_readdata),
        .o_avs_waitrequest(o_avs_waitrequest), .o_conv_clk(conv_clk),
        .o_conversion_start_strobe(start), .o_read_strobe(rd_strobe),
        .o_chip_select_n(cs_n), .o_serial_in_pin(serial_in_pin),
        .o_channel_method_strap(method), .o_output_lane_strap(lane),
        .i_busy(busy), .i_first_serial_out(sdo_a),
        .i_second_serial_out(sdo_b));
    dacsc_dev u_dacsc_dev (.i_conv_clk(conv_clk), .i_start(start),
        .i_read(rd_strobe), .i_cs_n(cs_n), .i_sdi(serial_in_pin), .i_method(method),
        .i_lane(lane), .o_busy(busy), .o_sdo_a(sdo_a), .o_sdo_b(sdo_b));
    task stop_test;
        begin
            $display("checks %0d mismatches %0d", tests_run, num_errors);
            if (num_errors == 0 && tests_run > 0)
                $display("Testbench passed");
            else
                $display("Testbench failed");
            $finish;
        end
    endtask
    task chk(input string name, input [31:0] seen, input [31:0] exp);
        begin
            tests_run = tests_run + 1;
            if (seen !== exp) begin
                num_errors = num_errors + 1;
                $display("[FAIL] %s expected %h seen %h", name, exp, seen);
            end
        end
    endtask
    // one Avalon access, held until waitrequest is sampled low
    task bus(input wr, input [2:0] a, input [31:0] d);
        integer n;
        begin
            n = 0;
            i_avs_address <= a;
            i_avs_writedata <= d;
            i_avs_write <= wr;
            i_avs_read <= !wr;
            do begin
                @(posedge i_mclk);
                n = n + 1;
            end while (o_avs_waitrequest !== 1'b0 && n < 20);
            q = o_avs_readdata;
            if (n >= 20)
                num_errors = num_errors + 1;
            i_avs_read <= 1'b0;
            i_avs_write <= 1'b0;
            @(posedge i_mclk);
        end
    endtask
    task rd(input string name, input [2:0] a, input [31:0] m,
            input [31:0] exp);
        begin
            bus(1'b0, a, 32'h0);
            chk(name, q & m, exp);
        end
    endtask
    // repeated reads until the masked field reaches a value
    task poll(input [2:0] a, input [31:0] m, input [31:0] want);
        integer n;
        begin
            n = 0;
            do begin
                bus(1'b0, a, 32'h0);
                n = n + 1;
            end while ((q & m) !== want && n < 900);
            chk("poll", q & m, want);
        end
    endtask
    initial begin
        i_mclk = 1'b0;
        forever #5 i_mclk = ~i_mclk;
    end
    // watchdog against a hung access or frame
    always @(posedge i_mclk) begin
        cyc = cyc + 1;
        if (cyc == 20000) begin
            num_errors = num_errors + 1;
            stop_test;
        end
    end
    // main sequence
    initial begin
        {num_errors, tests_run, cyc} = 96'h0;
        i_sys_rst = 1'b1;
        {i_avs_read, i_avs_write, i_avs_address} = 5'h00;
        i_avs_writedata = 32'h0;
        repeat (6) @(posedge i_mclk);
        i_sys_rst <= 1'b0;
        chk("cs_n", {31'h0, cs_n}, 32'h1);
        chk("conv_clk", {31'h0, conv_clk}, 32'h0);
        @(posedge i_mclk);
        rd("ctrl", `DACSC_REG_CTRL, 32'h3f, 32'h0);
        rd("cfg", `DACSC_REG_CFG, 32'hffff, 32'h0);
        rd("unmapped", 3'h5, 32'hffffffff, 32'h0);
        bus(1'b1, `DACSC_REG_STATUS, 32'hffffffff);
        rd("status", `DACSC_REG_STATUS, 32'h3c, 32'h0);
        for (k = 0; k < 4; k = k + 1) begin
            bus(1'b1, `DACSC_REG_CTRL, k << 1);
            @(posedge i_mclk);
            chk("method", {31'h0, method}, {31'h0, k[0]});
            chk("lane", {31'h0, lane}, {31'h0, k[1]});
        end
        bus(1'b1, `DACSC_REG_CFG, 32'h0050);
        bus(1'b1, `DACSC_REG_CMD, {28'h0, `DACSC_ADDR_REFDAC_A});
        rd("cmd pending", `DACSC_REG_STATUS, 32'h10, 32'h10);
        bus(1'b1, `DACSC_REG_CTRL, RUN);
        poll(`DACSC_REG_STATUS, 32'h8, 32'h8);
        rd("result", `DACSC_REG_RESULT, 32'hffffffff, 32'h5a3cc3a5);
        rd("clamp flag", `DACSC_REG_STATUS, 32'h20, 32'h20);
        chk("ref code", {22'h0, u_dacsc_dev.refdac_a}, 32'h0cd);
        bus(1'b1, `DACSC_REG_CTRL, DRST | 32'h1 << `DACSC_CTRL_ONESHOT);
        poll(`DACSC_REG_CTRL, DRST, 32'h0);
        poll(`DACSC_REG_STATUS, 32'h4, 32'h0);
        chk("ref reset", {22'h0, u_dacsc_dev.refdac_a}, 32'h3ff);
        chk("ref off", {31'h0, u_dacsc_dev.ref_power_down_bit}, 32'h1);
        stop_test;
    end
endmodule
